// ==== core/bju_pkg.sv ====
// bju_pkg: opcodes, field positions and link constants for the
// branch and jump unit; shared by the main file, the bju_cond leaf and the checker.
package bju_pkg;

  localparam int XLEN = 32;
  localparam int IMM_W = 16;
  localparam int JIDX_W = 26;
  localparam int REG_W = 5;

  // primary opcode field [31:26]
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_REGIMM = 6'h01;
  localparam logic [5:0] OP_J = 6'h02;
  localparam logic [5:0] OP_JAL = 6'h03;
  localparam logic [5:0] OP_BEQ = 6'h04;
  localparam logic [5:0] OP_BNE = 6'h05;
  localparam logic [5:0] OP_BLEZ = 6'h06;
  localparam logic [5:0] OP_BGTZ = 6'h07;
  localparam logic [5:0] OP_ADDI = 6'h08;
  localparam logic [5:0] OP_BEQL = 6'h14;
  localparam logic [5:0] OP_BNEL = 6'h15;
  localparam logic [5:0] OP_BLEZL = 6'h16;
  localparam logic [5:0] OP_BGTZL = 6'h17;
  localparam logic [5:0] OP_LB = 6'h20;
  localparam logic [5:0] OP_SD = 6'h3f;

  // function field [5:0] under OP_SPECIAL
  localparam logic [5:0] FN_JUMP_REG = 6'h08;
  localparam logic [5:0] FN_JUMP_REG_LINK = 6'h09;
  localparam logic [5:0] FN_ADD = 6'h20;
  localparam logic [5:0] FN_SUB = 6'h22;

  // rt field codes under OP_REGIMM
  localparam logic [4:0] RI_BLTZ = 5'h00;
  localparam logic [4:0] RI_BGEZ = 5'h01;
  localparam logic [4:0] RI_BLTZL = 5'h02;
  localparam logic [4:0] RI_BGEZL = 5'h03;
  localparam logic [4:0] RI_BLTZAL = 5'h10;
  localparam logic [4:0] RI_BGEZAL = 5'h11;
  localparam logic [4:0] RI_BLTZALL = 5'h12;
  localparam logic [4:0] RI_BGEZALL = 5'h13;

  // field positions
  localparam int OP_LSB = 26;
  localparam int RS_LSB = 21;
  localparam int RT_LSB = 16;
  localparam int RD_LSB = 11;
  localparam int JTOP_W = 4;

  localparam logic [4:0] REG_LINK = 5'h1f;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
  localparam logic [31:0] LINK_STEP = 32'h0000_0008;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;

  typedef enum logic [2:0] {
    BJU_C_EQ = 3'b000,
    BJU_C_NE = 3'b001,
    BJU_C_LEZ = 3'b010,
    BJU_C_GTZ = 3'b011,
    BJU_C_LTZ = 3'b100,
    BJU_C_GEZ = 3'b101
  } bju_cond_t;

  typedef enum logic [1:0] {
    BJU_S_RUN = 2'b00,
    BJU_S_SLOT = 2'b01,
    BJU_S_NULL = 2'b10
  } bju_state_t;

endpackage

// ==== core/bju_cond.sv ====
// bju_cond: decides a branch outcome from one or two general
// register values; assumes operands already read, register 0 as zero.
`timescale 1ns/1ps
module bju_cond #(
  parameter int XLEN = 32
) (
  input wire bju_pkg::bju_cond_t i_cond,
  input wire logic [XLEN-1:0] i_src_a,
  input wire logic [XLEN-1:0] i_src_b,
  output logic o_taken
);

  // ==========================================================
  // condition test
  // ==========================================================
  logic neg;
  logic zero;
  assign neg = i_src_a[XLEN-1];
  assign zero = (i_src_a == '0);

  // no flags kept: outcome comes only from register values [RULE2]
  always_comb begin
    case (i_cond)
      bju_pkg::BJU_C_EQ: o_taken = (i_src_a == i_src_b);
      bju_pkg::BJU_C_NE: o_taken = (i_src_a != i_src_b);
      bju_pkg::BJU_C_LEZ: o_taken = neg | zero;
      bju_pkg::BJU_C_GTZ: o_taken = ~neg & ~zero;
      bju_pkg::BJU_C_LTZ: o_taken = neg;
      bju_pkg::BJU_C_GEZ: o_taken = ~neg;
      default: o_taken = 1'b0;
    endcase
  end

endmodule

// ==== core/bju_addr.sv ====
// bju_addr: base plus sign-extended 16-bit displacement adder;
// used for load/store addresses and for pc-relative branch targets.
`timescale 1ns/1ps
module bju_addr #(
  parameter int XLEN = 32,
  parameter int IMM_W = 16
) (
  input wire logic [XLEN-1:0] i_base,
  input wire logic [IMM_W-1:0] i_disp,
  input wire logic i_word_scale,
  output logic [XLEN-1:0] o_sum
);

  // ==========================================================
  // displacement extension
  // ==========================================================
  logic [XLEN-1:0] disp_ext;
  always_comb begin
    disp_ext = {{(XLEN-IMM_W){i_disp[IMM_W-1]}}, i_disp};
    if (i_word_scale) begin
      disp_ext = {disp_ext[XLEN-3:0], 2'b00};
    end
  end

  assign o_sum = i_base + disp_ext;

endmodule

// ==== core/bju_top.sv ====
// bju_top: branch, jump and address generation for the integer core.
// assumes the decode stage presents one instruction per valid cycle
// with its pc and both register operands already read.
//
// Behaviour
// RULE1: load and store addresses are base register plus sign-extended 16-bit displacement only.
// RULE2: there is no condition-code register; branches test one or compare two registers.
// RULE3: conditional branch targets are always pc-relative.
// RULE4: the branch displacement is a 16-bit word count, reaching +/-32768 instructions.
// RULE5: every branch is conditional, link forms too; always-true conditions make it unconditional.
// RULE6: ordinary branches and jumps always execute the following delay-slot instruction.
// RULE7: likely branches take on the same condition but cancel the delay slot when not taken.
// RULE8: the absolute jump target takes 28 low bits from the instruction, top 4 from the pc.
// RULE9: the goto_register jump takes its whole target from a general register.
// RULE10: call jumps write pc plus 8 into register 31 as the return_link; the register form here writes its rd field instead when rd is nonzero.
// RULE11: jumps have a delay slot at pc plus 4, so the return point lies past it.
// RULE12: trapping add and subtract raise an exception on signed overflow, no flag kept.
// RULE13: branch target is the delay-slot address plus the displacement shifted left two.
// RULE14: register 0 always reads zero, so equal-compare of register 0 with itself takes.
`timescale 1ns/1ps
module bju_top #(
  parameter int XLEN = 32,
  parameter logic [XLEN-1:0] RESET_PC = bju_pkg::RESET_PC
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [XLEN-1:0] i_pc,
  input wire logic [XLEN-1:0] i_rs_val,
  input wire logic [XLEN-1:0] i_rt_val,
  output logic o_redirect,
  output logic [XLEN-1:0] o_target,
  output logic o_slot_nullify,
  output logic o_link_we,
  output logic [4:0] o_link_reg,
  output logic [XLEN-1:0] o_return_link,
  output logic o_mem_valid,
  output logic [XLEN-1:0] o_mem_addr,
  output logic o_ovf_trap,
  output logic [XLEN-1:0] o_trap_pc,
  output logic [XLEN-1:0] o_arith_res
);

  // ==========================================================
  // field decode
  // ==========================================================
  logic [5:0] opcode;
  logic [5:0] funct;
  logic [4:0] rs_idx;
  logic [4:0] rt_idx;
  logic [4:0] rd_idx;
  logic [15:0] imm;
  logic [25:0] jidx;
  assign opcode = i_instr[bju_pkg::OP_LSB +: 6];
  assign funct = i_instr[5:0];
  assign rs_idx = i_instr[bju_pkg::RS_LSB +: 5];
  assign rt_idx = i_instr[bju_pkg::RT_LSB +: 5];
  assign rd_idx = i_instr[bju_pkg::RD_LSB +: 5];
  assign imm = i_instr[15:0];
  assign jidx = i_instr[25:0];

  // register 0 reads as zero whatever the file feeds in [RULE14]
  logic [XLEN-1:0] rs_v;
  logic [XLEN-1:0] rt_v;
  assign rs_v = (rs_idx == bju_pkg::REG_ZERO) ? '0 : i_rs_val;
  assign rt_v = (rt_idx == bju_pkg::REG_ZERO) ? '0 : i_rt_val;

  // ==========================================================
  // instruction classes
  // ==========================================================
  logic is_branch;
  logic is_likely;
  logic br_link;
  bju_pkg::bju_cond_t cond;
  logic is_jabs;
  logic is_jreg;
  logic j_link;
  logic is_mem;
  logic is_tadd;
  logic is_tsub;

  // every branch, link forms included, goes through the condition test
  always_comb begin
    is_branch = 1'b1; // [RULE5]
    is_likely = 1'b0;
    br_link = 1'b0;
    cond = bju_pkg::BJU_C_EQ;
    case (opcode)
      bju_pkg::OP_BEQ: cond = bju_pkg::BJU_C_EQ;
      bju_pkg::OP_BNE: cond = bju_pkg::BJU_C_NE;
      bju_pkg::OP_BLEZ: cond = bju_pkg::BJU_C_LEZ;
      bju_pkg::OP_BGTZ: cond = bju_pkg::BJU_C_GTZ;
      bju_pkg::OP_BEQL: begin
        cond = bju_pkg::BJU_C_EQ;
        is_likely = 1'b1;
      end
      bju_pkg::OP_BNEL: begin
        cond = bju_pkg::BJU_C_NE;
        is_likely = 1'b1;
      end
      bju_pkg::OP_BLEZL: begin
        cond = bju_pkg::BJU_C_LEZ;
        is_likely = 1'b1;
      end
      bju_pkg::OP_BGTZL: begin
        cond = bju_pkg::BJU_C_GTZ;
        is_likely = 1'b1;
      end
      bju_pkg::OP_REGIMM: begin
        case (rt_idx)
          bju_pkg::RI_BLTZ: cond = bju_pkg::BJU_C_LTZ;
          bju_pkg::RI_BGEZ: cond = bju_pkg::BJU_C_GEZ;
          bju_pkg::RI_BLTZL: begin
            cond = bju_pkg::BJU_C_LTZ;
            is_likely = 1'b1;
          end
          bju_pkg::RI_BGEZL: begin
            cond = bju_pkg::BJU_C_GEZ;
            is_likely = 1'b1;
          end
          bju_pkg::RI_BLTZAL: begin
            cond = bju_pkg::BJU_C_LTZ;
            br_link = 1'b1;
          end
          bju_pkg::RI_BGEZAL: begin
            cond = bju_pkg::BJU_C_GEZ;
            br_link = 1'b1;
          end
          bju_pkg::RI_BLTZALL: begin
            cond = bju_pkg::BJU_C_LTZ;
            br_link = 1'b1;
            is_likely = 1'b1;
          end
          bju_pkg::RI_BGEZALL: begin
            cond = bju_pkg::BJU_C_GEZ;
            br_link = 1'b1;
            is_likely = 1'b1;
          end
          default: is_branch = 1'b0;
        endcase
      end
      default: is_branch = 1'b0;
    endcase
  end

  assign is_jabs = (opcode == bju_pkg::OP_J) || (opcode == bju_pkg::OP_JAL);
  assign is_jreg = (opcode == bju_pkg::OP_SPECIAL)
                   && ((funct == bju_pkg::FN_JUMP_REG)
                   || (funct == bju_pkg::FN_JUMP_REG_LINK));
  assign j_link = (opcode == bju_pkg::OP_JAL)
                  || (is_jreg && funct == bju_pkg::FN_JUMP_REG_LINK);
  // loads and stores span the 0x20..0x3f opcode block
  assign is_mem = (opcode >= bju_pkg::OP_LB) && (opcode <= bju_pkg::OP_SD);
  assign is_tadd = (opcode == bju_pkg::OP_ADDI)
                   || ((opcode == bju_pkg::OP_SPECIAL)
                   && (funct == bju_pkg::FN_ADD));
  assign is_tsub = (opcode == bju_pkg::OP_SPECIAL)
                   && (funct == bju_pkg::FN_SUB);

  // ==========================================================
  // condition and address generation
  // ==========================================================
  logic taken;
  bju_cond #(
    .XLEN(XLEN)
  ) u_cond (
    .i_cond(cond),
    .i_src_a(rs_v),
    .i_src_b(rt_v),
    .o_taken(taken)
  );

  logic [XLEN-1:0] slot_pc;
  logic [XLEN-1:0] br_target;
  logic [XLEN-1:0] mem_addr;
  // delay-slot address is the base of every pc-relative target [RULE11]
  assign slot_pc = i_pc + bju_pkg::SLOT_STEP;

  // word-scaled 16-bit displacement added to the slot pc [RULE3] [RULE4]
  bju_addr #(
    .XLEN(XLEN),
    .IMM_W(bju_pkg::IMM_W)
  ) u_br_addr (
    .i_base(slot_pc),
    .i_disp(imm),
    .i_word_scale(1'b1), // [RULE13]
    .o_sum(br_target)
  );

  // base register plus signed byte offset, the only memory form [RULE1]
  bju_addr #(
    .XLEN(XLEN),
    .IMM_W(bju_pkg::IMM_W)
  ) u_mem_addr (
    .i_base(rs_v),
    .i_disp(imm),
    .i_word_scale(1'b0),
    .o_sum(mem_addr)
  );

  // top 4 bits kept from the pc, low 28 from the index [RULE8]
  logic [XLEN-1:0] jabs_target;
  assign jabs_target = {i_pc[XLEN-1 -: bju_pkg::JTOP_W], jidx, 2'b00};

  // ==========================================================
  // trapping arithmetic
  // ==========================================================
  logic [XLEN-1:0] op_b;
  logic [XLEN-1:0] arith;
  logic ovf;
  always_comb begin
    op_b = (opcode == bju_pkg::OP_ADDI) ? {{16{imm[15]}}, imm} : rt_v;
    if (is_tsub) begin
      arith = rs_v - op_b;
      ovf = (rs_v[XLEN-1] != op_b[XLEN-1])
            && (arith[XLEN-1] != rs_v[XLEN-1]);
    end else begin
      arith = rs_v + op_b;
      ovf = (rs_v[XLEN-1] == op_b[XLEN-1])
            && (arith[XLEN-1] != rs_v[XLEN-1]);
    end
  end

  // ==========================================================
  // delay-slot tracking
  // ==========================================================
  // a transfer's slot is never itself a transfer; the following
  // instruction is the slot and is either run or cancelled
  bju_pkg::bju_state_t state_reg;
  bju_pkg::bju_state_t state_next;
  logic act;
  logic xfer;
  logic do_redirect;
  assign act = i_valid && (state_reg != bju_pkg::BJU_S_NULL);
  assign xfer = is_jabs || is_jreg || (is_branch && taken);
  assign do_redirect = act && (state_reg == bju_pkg::BJU_S_RUN) && xfer;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bju_pkg::BJU_S_RUN: begin
        if (i_valid && (is_branch || is_jabs || is_jreg)) begin
          if (is_likely && !taken) begin
            state_next = bju_pkg::BJU_S_NULL; // [RULE7]
          end else begin
            state_next = bju_pkg::BJU_S_SLOT; // [RULE6]
          end
        end
      end
      bju_pkg::BJU_S_SLOT: if (i_valid) state_next = bju_pkg::BJU_S_RUN;
      bju_pkg::BJU_S_NULL: if (i_valid) state_next = bju_pkg::BJU_S_RUN;
      default: state_next = bju_pkg::BJU_S_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= bju_pkg::BJU_S_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // redirect and link outputs
  // ==========================================================
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_redirect <= 1'b0;
      o_target <= RESET_PC;
      o_slot_nullify <= 1'b0;
    end else begin
      o_redirect <= do_redirect;
      o_slot_nullify <= act && (state_reg == bju_pkg::BJU_S_RUN)
                        && is_branch && is_likely && !taken; // [RULE7]
      if (do_redirect) begin
        if (is_jreg) begin
          o_target <= rs_v; // [RULE9]
        end else if (is_jabs) begin
          o_target <= jabs_target; // [RULE8]
        end else begin
          o_target <= br_target; // [RULE3]
        end
      end
    end
  end

  // link forms write pc plus 8, past the slot [RULE10] [RULE11]
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_link_we <= 1'b0;
      o_link_reg <= bju_pkg::REG_LINK;
      o_return_link <= '0;
    end else begin
      o_link_we <= act && (state_reg == bju_pkg::BJU_S_RUN)
                   && (j_link || br_link);
      if (act && (j_link || br_link)) begin
        o_return_link <= i_pc + bju_pkg::LINK_STEP;
        // register form may name its own link target; default is 31
        if (is_jreg && rd_idx != bju_pkg::REG_ZERO) begin
          o_link_reg <= rd_idx;
        end else begin
          o_link_reg <= bju_pkg::REG_LINK;
        end
      end
    end
  end

  // ==========================================================
  // memory address and overflow trap
  // ==========================================================
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_valid <= 1'b0;
      o_mem_addr <= '0;
    end else begin
      o_mem_valid <= act && is_mem; // [RULE1]
      if (act && is_mem) begin
        o_mem_addr <= mem_addr;
      end
    end
  end

  // trap is a one-cycle event; nothing sticky is kept [RULE12]
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ovf_trap <= 1'b0;
      o_trap_pc <= '0;
      o_arith_res <= '0;
    end else begin
      o_ovf_trap <= act && (is_tadd || is_tsub) && ovf;
      if (act && (is_tadd || is_tsub)) begin
        o_arith_res <= arith;
        o_trap_pc <= i_pc;
      end
    end
  end

endmodule

// ==== sim/bju_top_asserts.sv ====
// bju_top_asserts: port-level timing checks for the branch/jump unit.
// assumes one core clock, async active-low reset, latency of one edge.
`timescale 1ns/1ps
module bju_chk (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_rs_val,
  input wire logic [31:0] i_rt_val,
  input wire logic o_redirect,
  input wire logic [31:0] o_target,
  input wire logic o_slot_nullify,
  input wire logic o_link_we,
  input wire logic [4:0] o_link_reg,
  input wire logic [31:0] o_return_link,
  input wire logic o_mem_valid,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_ovf_trap,
  input wire logic [31:0] o_trap_pc,
  input wire logic [31:0] o_arith_res
);
  // ==========================================
  // decode helpers
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire [5:0] op = i_instr[31:26];
  wire [5:0] fn = i_instr[5:0];
  wire [31:0] sx = {{14{i_instr[15]}}, i_instr[15:0], 2'b00};
  wire [31:0] dsp = {{16{i_instr[15]}}, i_instr[15:0]};
  // index 0 reads as zero whatever the file feeds
  wire [31:0] rsv = (i_instr[25:21] == 5'h00) ? 32'h0000_0000 : i_rs_val;
  wire [31:0] rtv = (i_instr[20:16] == 5'h00) ? 32'h0000_0000 : i_rt_val;
  wire [31:0] sum = rsv + rtv;
  wire ovf = (rsv[31] == rtv[31]) && (sum[31] != rsv[31]);
  wire xfer = (op >= 6'h01 && op <= 6'h07) || (op >= 6'h14 && op <= 6'h17)
    || (op == 6'h00 && (fn == 6'h08 || fn == 6'h09));
  // slot tracking, so that transfers sitting in a slot are not judged
  logic slot_reg;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      slot_reg <= 1'b0;
    end else if (i_valid) begin
      slot_reg <= xfer && !o_slot_nullify && !slot_reg;
    end
  end
  wire live = i_valid && !o_slot_nullify && !slot_reg;

  // ==========================================
  // properties
  sequence s_likely_miss;
    live && op == bju_pkg::OP_BEQL && i_rs_val != i_rt_val
      && i_instr[25:21] != 5'h00 && i_instr[20:16] != 5'h00;
  endsequence
  sequence s_call;
    live && op == bju_pkg::OP_JAL;
  endsequence

  a_mem_addr: assert property (live && op >= bju_pkg::OP_LB |=>
    o_mem_valid && o_mem_addr == $past(rsv) + $past(dsp))
    else $error("load/store address wrong");
  a_beq_zero: assert property (live && op == bju_pkg::OP_BEQ
    && i_instr[25:16] == 10'h000 |=> o_redirect
    && o_target == $past(i_pc) + 32'h0000_0004 + $past(sx))
    else $error("beq zero target wrong");
  a_likely_miss: assert property (s_likely_miss |=>
    o_slot_nullify && !o_redirect)
    else $error("likely miss not nullified");
  a_null_quiet: assert property (o_slot_nullify && i_valid |=>
    !o_redirect && !o_mem_valid && !o_link_we)
    else $error("nullified slot had effect");
  a_plain_slot: assert property (live && op == bju_pkg::OP_BNE |=>
    !o_slot_nullify)
    else $error("ordinary branch nullified slot");
  a_jump_abs: assert property (live && op == bju_pkg::OP_J |=>
    o_redirect && !o_link_we && o_target ==
    {$past(i_pc[31:28]), $past(i_instr[25:0]), 2'b00})
    else $error("absolute jump target wrong");
  a_call_link: assert property (s_call |=> o_link_we
    && o_link_reg == bju_pkg::REG_LINK
    && o_return_link == $past(i_pc) + bju_pkg::LINK_STEP)
    else $error("call link wrong");
  a_goto_reg: assert property (live && op == 6'h00
    && fn == bju_pkg::FN_JUMP_REG |=> o_redirect
    && o_target == $past(rsv))
    else $error("register jump target wrong");
  a_add_trap: assert property (live && op == 6'h00
    && fn == bju_pkg::FN_ADD && ovf |=> o_ovf_trap
    && o_trap_pc == $past(i_pc))
    else $error("add overflow not trapped");
  a_add_clean: assert property (live && op == 6'h00
    && fn == bju_pkg::FN_ADD && !ovf |=> !o_ovf_trap
    && o_arith_res == $past(sum))
    else $error("clean add trapped or wrong");
endmodule

bind bju_top bju_chk u_chk (.i_clk_sys, .i_rstn, .i_valid, .i_instr, .i_pc,
  .i_rs_val, .i_rt_val, .o_redirect, .o_target, .o_slot_nullify, .o_link_we,
  .o_link_reg, .o_return_link, .o_mem_valid, .o_mem_addr, .o_ovf_trap,
  .o_trap_pc, .o_arith_res);

// ==== sim/tb_top.sv ====
// tb_top: directed scenarios for the branch/jump unit.
// assumes outputs answer exactly one edge after the request.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZRO = 32'h0000_0000;
  logic i_clk_sys, i_rstn, i_valid;
  logic [31:0] i_instr, i_pc, i_rs_val, i_rt_val;
  logic o_redirect, o_slot_nullify, o_link_we, o_mem_valid, o_ovf_trap;
  logic [4:0] o_link_reg;
  logic [31:0] o_target, o_return_link, o_mem_addr, o_trap_pc, o_arith_res;
  int errors = 0;
  int n_checks = 0;

  bju_top dut (.i_clk_sys, .i_rstn, .i_valid, .i_instr, .i_pc, .i_rs_val,
    .i_rt_val, .o_redirect, .o_target, .o_slot_nullify, .o_link_we,
    .o_link_reg, .o_return_link, .o_mem_valid, .o_mem_addr, .o_ovf_trap,
    .o_trap_pc, .o_arith_res);

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================
  // helpers
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // drives one cycle; on return the answer of that cycle is visible
  task automatic step(input logic v, input logic [31:0] ins, pc, rs, rt);
    i_valid = v;
    i_instr = ins;
    i_pc = pc;
    i_rs_val = rs;
    i_rt_val = rt;
    @(posedge i_clk_sys);
    #1;
  endtask

  function automatic logic [31:0] ity(logic [5:0] op, logic [4:0] s, t,
                                      logic [15:0] imm);
    return {op, s, t, imm};
  endfunction

  function automatic logic [31:0] rty(logic [4:0] s, t, d, logic [5:0] f);
    return {6'h00, s, t, d, 5'h00, f};
  endfunction

  function automatic logic [31:0] btgt(logic [31:0] pc, logic [15:0] imm);
    return pc + 32'h0000_0004 + {{14{imm[15]}}, imm, 2'b00};
  endfunction

  // ==========================================
  // scenarios
  task automatic t_mem();
    step(1, ity(bju_pkg::OP_LB, 5'h03, 5'h02, 16'h8000), 32'h0000_0100,
         32'h0001_0000, ZRO);
    check("mem_valid", o_mem_valid, ONE);
    check("mem_addr neg", o_mem_addr, 32'h0000_8000);
    step(1, ity(bju_pkg::OP_SD, 5'h03, 5'h02, 16'h7fff), 32'h0000_0104,
         32'hffff_0000, ZRO);
    check("mem_addr pos", o_mem_addr, 32'hffff_7fff);
  endtask

  task automatic t_branch();
    // rs value is junk: index zero must still read as zero
    step(1, ity(bju_pkg::OP_BEQ, 5'h00, 5'h00, 16'h8000), 32'h0004_0000,
         32'hdead_beef, 32'h1234_5678);
    check("beq0 taken", o_redirect, ONE);
    check("beq0 target", o_target, 32'h0002_0004);
    step(1, ity(bju_pkg::OP_LB, 5'h01, 5'h02, 16'h0000), 32'h0004_0004,
         32'h0000_0040, ZRO);
    check("slot runs", o_mem_valid, ONE);
  endtask

  task automatic t_cond();
    logic [5:0] op [12] = '{6'h05, 6'h05, 6'h06, 6'h06, 6'h07, 6'h07,
                            6'h01, 6'h01, 6'h01, 6'h01, 6'h01, 6'h01};
    logic [4:0] rf [12] = '{5'h02, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00,
                            5'h00, 5'h00, 5'h01, 5'h01, 5'h11, 5'h10};
    logic [31:0] rv [12] = '{32'h0000_0005, 32'h0000_0006, ZRO, ONE, ONE,
                             32'h8000_0000, 32'hffff_ffff, ZRO, ZRO,
                             32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    logic tk [12] = '{0, 1, 1, 0, 1, 0, 1, 0, 1, 0, 0, 1};
    logic [31:0] p;
    for (int k = 0; k < 12; k++) begin
      p = 32'h0000_1000 + 32'(k * 256);
      step(1, {op[k], 5'h01, rf[k], 16'hfffe}, p, rv[k], 32'h0000_0005);
      check("taken", o_redirect, tk[k]);
      if (tk[k]) check("target", o_target, btgt(p, 16'hfffe));
      check("link_we", o_link_we, k > 9);
      step(1, ZRO, p + 32'h0000_0004, ZRO, ZRO);
    end
  endtask

  task automatic t_likely();
    step(1, ity(bju_pkg::OP_BEQL, 5'h01, 5'h02, 16'h0004), 32'h0000_2000,
         ONE, 32'h0000_0002);
    check("likely null", o_slot_nullify, ONE);
    check("likely miss", o_redirect, ZRO);
    step(1, ity(bju_pkg::OP_LB, 5'h01, 5'h02, 16'h0000), 32'h0000_2004,
         32'h0000_0040, ZRO);
    check("slot cancelled", o_mem_valid, ZRO);
    step(1, ity(bju_pkg::OP_BEQL, 5'h01, 5'h02, 16'h0004), 32'h0000_2008,
         32'h0000_0007, 32'h0000_0007);
    check("likely hit", o_redirect, ONE);
    check("likely keep", o_slot_nullify, ZRO);
    check("likely tgt", o_target, btgt(32'h0000_2008, 16'h0004));
    step(1, ity(bju_pkg::OP_LB, 5'h01, 5'h02, 16'h0000), 32'h0000_200c,
         32'h0000_0040, ZRO);
    check("slot kept", o_mem_valid, ONE);
    step(1, ity(bju_pkg::OP_REGIMM, 5'h01, bju_pkg::RI_BLTZALL, 16'h0004),
         32'h0000_2010, ONE, ZRO);
    check("likely link null", o_slot_nullify, ONE);
    check("likely link miss", o_redirect, ZRO);
    check("likely link ret", o_return_link, 32'h0000_2018);
    step(1, ity(bju_pkg::OP_LB, 5'h01, 5'h02, 16'h0000), 32'h0000_2014,
         32'h0000_0040, ZRO);
    check("link slot null", o_mem_valid, ZRO);
  endtask

  task automatic t_jump();
    step(1, {bju_pkg::OP_J, 26'h3ff_ffff}, 32'ha000_0100, ZRO, ZRO);
    check("j target", o_target, 32'hafff_fffc);
    check("j nolink", o_link_we, ZRO);
    step(1, ZRO, 32'ha000_0104, ZRO, ZRO);
    step(1, {bju_pkg::OP_JAL, 26'h000_0010}, 32'h5000_0200, ZRO, ZRO);
    check("jal target", o_target, 32'h5000_0040);
    check("jal link_we", o_link_we, ONE);
    check("jal link_reg", o_link_reg, 32'h0000_001f);
    check("jal ret", o_return_link, 32'h5000_0208);
    step(1, ZRO, 32'h5000_0204, ZRO, ZRO);
    step(1, rty(5'h03, 5'h00, 5'h1f, bju_pkg::FN_JUMP_REG_LINK),
         32'h0000_0300, 32'h1234_5670, ZRO);
    check("call reg tgt", o_target, 32'h1234_5670);
    check("call reg ret", o_return_link, 32'h0000_0308);
    step(1, ZRO, 32'h0000_0304, ZRO, ZRO);
    step(1, rty(5'h1f, 5'h00, 5'h00, bju_pkg::FN_JUMP_REG), 32'h0000_0400,
         32'hbfc0_0000, ZRO);
    check("goto redirect", o_redirect, ONE);
    check("goto target", o_target, 32'hbfc0_0000);
    step(1, ZRO, 32'h0000_0404, ZRO, ZRO);
  endtask

  task automatic t_trap();
    step(1, rty(5'h01, 5'h02, 5'h03, bju_pkg::FN_ADD), 32'h0000_0500,
         32'h7fff_ffff, ONE);
    check("add trap", o_ovf_trap, ONE);
    check("trap pc", o_trap_pc, 32'h0000_0500);
    step(1, rty(5'h01, 5'h02, 5'h03, bju_pkg::FN_SUB), 32'h0000_0504,
         32'h0000_0009, 32'h0000_0003);
    check("sub clean", o_ovf_trap, ZRO);
    check("sub result", o_arith_res, 32'h0000_0006);
    step(1, rty(5'h01, 5'h02, 5'h03, bju_pkg::FN_SUB), 32'h0000_0508,
         32'h8000_0000, ONE);
    check("sub trap", o_ovf_trap, ONE);
    step(1, rty(5'h01, 5'h02, 5'h03, bju_pkg::FN_ADD), 32'h0000_050c,
         32'h0000_0003, 32'hffff_ffff);
    check("add clean", o_ovf_trap, ZRO);
    check("add result", o_arith_res, 32'h0000_0002);
    step(1, ity(bju_pkg::OP_ADDI, 5'h01, 5'h02, 16'hffff), 32'h0000_0510,
         32'h0000_0005, 32'h7fff_ffff);
    check("addi result", o_arith_res, 32'h0000_0004);
    check("addi clean", o_ovf_trap, ZRO);
    check("addi pc", o_trap_pc, 32'h0000_0510);
    step(1, ity(bju_pkg::OP_ADDI, 5'h01, 5'h02, 16'hffff), 32'h0000_0514,
         32'h8000_0000, ZRO);
    check("addi trap", o_ovf_trap, ONE);
  endtask

  // ==========================================
  // closing
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    i_rstn = 1'b0;
    i_valid = 1'b0;
    i_instr = ZRO;
    i_pc = ZRO;
    i_rs_val = ZRO;
    i_rt_val = ZRO;
    repeat (5) @(posedge i_clk_sys);
    #1;
    i_rstn = 1'b1;
    t_mem();
    t_branch();
    t_cond();
    t_likely();
    t_jump();
    t_trap();
    step(0, ZRO, ZRO, ZRO, ZRO);
    finish_test();
  end

  // hang guard: the run is about 54 cycles
  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule
